// ### pkg/pfrb_pkg.sv
// Constants and carrier types for the protection and fault register bank.
// Assumes a 125 MHz mclk and an AXI4-Lite master with 32-bit data.
package pfrb_pkg;

  // Register indices; byte address is four times the index
  localparam int unsigned ADDR_W = 10;
  localparam logic [7:0] IDX_PROT_CTRL = 8'h50;
  localparam logic [7:0] IDX_OVP_THR   = 8'h51;
  localparam logic [7:0] IDX_MASK_C    = 8'h52;
  localparam logic [7:0] IDX_FLAGS_C   = 8'h53;
  localparam logic [7:0] IDX_STATUS    = 8'h54;
  localparam logic [7:0] IDX_SOFT_CTRL = 8'h55;

  // Reset values
  localparam logic [7:0] RST_PROT_CTRL = 8'h43;
  localparam logic [6:0] RST_OVP_THR   = 7'h14;
  localparam logic [3:0] RST_MASK_C    = 4'h1;
  localparam logic [4:0] RST_FLAGS_C   = 5'h00;
  localparam logic [9:0] RST_SENSE     = 10'h010;

  // Field positions, protection control
  localparam int unsigned CTL_TSHDN_LSB = 6;
  localparam int unsigned CTL_DGL_SEL   = 4;
  localparam int unsigned CTL_OVP_EN    = 3;
  localparam int unsigned CTL_SWF_EN    = 2;
  localparam int unsigned CTL_RCB_EN    = 1;
  localparam int unsigned CTL_OCP_EN    = 0;
  localparam logic [7:0] CTL_WR_MASK    = 8'hdf;

  // Field positions, mask and flag registers
  localparam int unsigned FLG_WDOG   = 4;
  localparam int unsigned FLG_OVP    = 3;
  localparam int unsigned FLG_SWFAIL = 2;
  localparam int unsigned FLG_USBOVP = 1;
  localparam int unsigned FLG_USBINS = 0;

  // Soft control: register reset bit
  localparam int unsigned SOFT_REG_RST = 0;

  // Threshold saturation code
  localparam logic [6:0] OVP_THR_MAX = 7'h50;

  // Deglitch timing
  localparam int unsigned CLK_MHZ      = 125;
  localparam int unsigned DGL_SHORT_US = 4;
  localparam int unsigned DGL_LONG_US  = 20;
  localparam logic [11:0] DGL_SHORT_CYC = 12'(DGL_SHORT_US * CLK_MHZ);
  localparam logic [11:0] DGL_LONG_CYC  = 12'(DGL_LONG_US * CLK_MHZ);

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Comparator and loop levels from the analog side (asynchronous)
  typedef struct packed {
    logic loop_vout;
    logic loop_vbat;
    logic loop_ibat;
    logic loop_ibus;
    logic bus_above_uvlo;
    logic snsp_above_insert;
    logic vout_above_thr;
    logic cs_above_fail;
    logic usb_above_ovp;
    logic usb_above_uvlo;
  } pfrb_sense_t;

  // Control fields handed to the protection circuits
  typedef struct packed {
    logic [1:0] thermal_shdn_sel;
    logic       out_overvolt_deglitch_sel;
    logic       out_overvolt_protect_enable;
    logic       switch_short_detect_enable;
    logic       reverse_current_block_enable;
    logic       input_overcurrent_enable;
    logic [6:0] out_overvolt_threshold;
  } pfrb_ctrl_t;

endpackage

// ### logic/pfrb_bank.sv
// Protection control, threshold, fault mask, fault flag and status registers.
// Assumes an AXI4-Lite master on mclk, analog levels arriving asynchronously,
// and switch enable, ADC enable and watchdog expiry pulses from mclk logic.
//
// Overview of operation
// - OVP deglitch: 0 gives 4 us, 1 gives 20 us
// - OVP enabled and tripped forces bypass open
// - Switch-short detection active when its enable set
// - Reverse blocking enable resets to 1, blocks
// - Input over-current enable gates current protection
// - Threshold code: 4.50 V base, saturates at 5.30
// - Pin, register reset, watchdog restore defaults
// - Watchdog flag survives watchdog-triggered defaults restore
// - Mask bits 3..0; insertion mask resets to 1
// - Masking blocks interrupt only, flags still set
// - OVP flag sets on trip, clears on read
// - Switch fail flag: source high while switch off
// - USB over-voltage flag sets above its threshold
// - USB insertion flag sets on both crossings
// - Status bits 7..4 show live loop activity
// - Input present forced 0 when switch, ADC off
// - Battery present status, resets to 1
// - Status bit 0 shows USB input present
// - Reserved bits read zero, ignore writes
//
// Added by the designer: the AXI4-Lite register port.
`timescale 1ns/10ps

module pfrb_bank
(
  input  wire logic                     mclk,
  input  wire logic                     rst_b,
  input  wire logic [pfrb_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                     s_axi_awvalid,
  output logic                          s_axi_awready,
  input  wire logic [31:0]              s_axi_wdata,
  input  wire logic [3:0]               s_axi_wstrb,
  input  wire logic                     s_axi_wvalid,
  output logic                          s_axi_wready,
  output logic [1:0]                    s_axi_bresp,
  output logic                          s_axi_bvalid,
  input  wire logic                     s_axi_bready,
  input  wire logic [pfrb_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                     s_axi_arvalid,
  output logic                          s_axi_arready,
  output logic [31:0]                   s_axi_rdata,
  output logic [1:0]                    s_axi_rresp,
  output logic                          s_axi_rvalid,
  input  wire logic                     s_axi_rready,
  input  wire pfrb_pkg::pfrb_sense_t    sense,
  input  wire logic                     bypass_switch_enable,
  input  wire logic                     adc_enable,
  input  wire logic                     wdog_expire,
  output pfrb_pkg::pfrb_ctrl_t          ctrl,
  output logic                          bypass_force_open,
  output logic                          int_n_o,
  output logic                          int_n_oe
);

  // Bus holding registers
  logic [pfrb_pkg::ADDR_W-1:0] aw_addr_q;
  logic                        aw_full_q;
  logic [7:0]                  w_data_q;
  logic                        w_lane0_q;
  logic                        w_full_q;
  logic                        bvalid_q;
  logic [1:0]                  bresp_q;
  logic                        rvalid_q;
  logic [1:0]                  rresp_q;
  logic [7:0]                  rdata_q;

  // Software-visible state
  logic [7:0]                  prot_ctrl_q;
  logic [6:0]                  ovp_thr_q;
  logic [3:0]                  mask_q;
  logic [4:0]                  flags_q;
  logic [4:0]                  flags_d;
  logic                        reg_rst_q;

  // Sense synchronisers and event state
  logic [9:0]                  sense_s1_q;
  logic [9:0]                  sense_s2_q;
  pfrb_pkg::pfrb_sense_t       sn;
  logic                        usb_prev_q;
  logic [11:0]                 dgl_cnt_q;
  logic                        ovp_filt_q;
  logic [11:0]                 dgl_limit;

  // Decode and strobes
  logic                        wr_go;
  logic                        rd_go;
  logic [7:0]                  wr_idx;
  logic [7:0]                  rd_idx;
  logic                        wr_hit;
  logic                        rd_hit;
  logic                        wr_en;
  logic                        soft_clr;
  logic [4:0]                  flag_set;
  logic [4:0]                  flag_clr;
  logic [7:0]                  status_rd;
  logic [7:0]                  rd_value;
  logic [6:0]                  thr_eff;

  assign sn = pfrb_pkg::pfrb_sense_t'(sense_s2_q);

  // AXI4-Lite slave
  assign s_axi_awready = !aw_full_q && !bvalid_q;
  assign s_axi_wready  = !w_full_q && !bvalid_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rresp   = rresp_q;
  assign s_axi_rdata   = {24'h000000, rdata_q};

  assign wr_go  = aw_full_q && w_full_q && !bvalid_q;
  assign rd_go  = s_axi_arvalid && !rvalid_q;
  assign wr_idx = aw_addr_q[pfrb_pkg::ADDR_W-1:2];
  assign rd_idx = s_axi_araddr[pfrb_pkg::ADDR_W-1:2];

  always_comb
  begin
    wr_hit = 1'b0;
    if (aw_addr_q[1:0] == 2'h0)
    begin
      case (wr_idx)
        pfrb_pkg::IDX_PROT_CTRL,
        pfrb_pkg::IDX_OVP_THR,
        pfrb_pkg::IDX_MASK_C,
        pfrb_pkg::IDX_FLAGS_C,
        pfrb_pkg::IDX_STATUS,
        pfrb_pkg::IDX_SOFT_CTRL: wr_hit = 1'b1;
        default:                 wr_hit = 1'b0;
      endcase
    end
  end

  // Only the low byte carries register data
  assign wr_en = wr_go && wr_hit && w_lane0_q;

  // Write address channel
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      aw_full_q <= 1'b0;
      aw_addr_q <= '0;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      aw_full_q <= 1'b1;
      aw_addr_q <= s_axi_awaddr;
    end
    else if (wr_go)
    begin
      aw_full_q <= 1'b0;
    end
  end

  // Write data channel
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      w_full_q  <= 1'b0;
      w_data_q  <= 8'h00;
      w_lane0_q <= 1'b0;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      w_full_q  <= 1'b1;
      w_data_q  <= s_axi_wdata[7:0];
      w_lane0_q <= s_axi_wstrb[0];
    end
    else if (wr_go)
    begin
      w_full_q <= 1'b0;
    end
  end

  // Write response
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      bvalid_q <= 1'b0;
      bresp_q  <= pfrb_pkg::RESP_OKAY;
    end
    else if (wr_go)
    begin
      bvalid_q <= 1'b1;
      bresp_q  <= wr_hit ? pfrb_pkg::RESP_OKAY : pfrb_pkg::RESP_SLVERR;
    end
    else if (s_axi_bready)
    begin
      bvalid_q <= 1'b0;
    end
  end

  // Read data mux; reserved bits come back as zero
  always_comb
  begin
    rd_hit   = s_axi_araddr[1:0] == 2'h0;
    rd_value = 8'h00;
    case (rd_idx)
      pfrb_pkg::IDX_PROT_CTRL: rd_value = prot_ctrl_q;
      pfrb_pkg::IDX_OVP_THR:   rd_value = {1'b0, ovp_thr_q};
      pfrb_pkg::IDX_MASK_C:    rd_value = {4'h0, mask_q};
      pfrb_pkg::IDX_FLAGS_C:   rd_value = {3'h0, flags_q};
      pfrb_pkg::IDX_STATUS:    rd_value = status_rd;
      pfrb_pkg::IDX_SOFT_CTRL: rd_value = 8'h00;
      default:                 rd_hit   = 1'b0;
    endcase
  end

  // Read response
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rvalid_q <= 1'b0;
      rdata_q  <= 8'h00;
      rresp_q  <= pfrb_pkg::RESP_OKAY;
    end
    else if (rd_go)
    begin
      rvalid_q <= 1'b1;
      rdata_q  <= rd_hit ? rd_value : 8'h00;
      rresp_q  <= rd_hit ? pfrb_pkg::RESP_OKAY : pfrb_pkg::RESP_SLVERR;
    end
    else if (s_axi_rready)
    begin
      rvalid_q <= 1'b0;
    end
  end

  // Soft reset sources
  // Register reset bit self-clears after one cycle
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      reg_rst_q <= 1'b0;
    end
    else
    begin
      reg_rst_q <= wr_en && wr_idx == pfrb_pkg::IDX_SOFT_CTRL &&
                   w_data_q[pfrb_pkg::SOFT_REG_RST];
    end
  end

  assign soft_clr = reg_rst_q || wdog_expire;

  // Control registers
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      prot_ctrl_q <= pfrb_pkg::RST_PROT_CTRL;
    end
    else if (soft_clr)
    begin
      prot_ctrl_q <= pfrb_pkg::RST_PROT_CTRL;
    end
    else if (wr_en && wr_idx == pfrb_pkg::IDX_PROT_CTRL)
    begin
      prot_ctrl_q <= w_data_q & pfrb_pkg::CTL_WR_MASK;
    end
  end

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ovp_thr_q <= pfrb_pkg::RST_OVP_THR;
    end
    else if (soft_clr)
    begin
      ovp_thr_q <= pfrb_pkg::RST_OVP_THR;
    end
    else if (wr_en && wr_idx == pfrb_pkg::IDX_OVP_THR)
    begin
      ovp_thr_q <= w_data_q[6:0];
    end
  end

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      mask_q <= pfrb_pkg::RST_MASK_C;
    end
    else if (soft_clr)
    begin
      mask_q <= pfrb_pkg::RST_MASK_C;
    end
    else if (wr_en && wr_idx == pfrb_pkg::IDX_MASK_C)
    begin
      mask_q <= w_data_q[3:0];
    end
  end

  // Codes past the top step all give the highest threshold
  assign thr_eff = (ovp_thr_q > pfrb_pkg::OVP_THR_MAX) ?
                   pfrb_pkg::OVP_THR_MAX : ovp_thr_q;

  always_comb
  begin
    ctrl.thermal_shdn_sel             =
      prot_ctrl_q[pfrb_pkg::CTL_TSHDN_LSB +: 2];
    ctrl.out_overvolt_deglitch_sel    = prot_ctrl_q[pfrb_pkg::CTL_DGL_SEL];
    ctrl.out_overvolt_protect_enable  = prot_ctrl_q[pfrb_pkg::CTL_OVP_EN];
    ctrl.switch_short_detect_enable   = prot_ctrl_q[pfrb_pkg::CTL_SWF_EN];
    ctrl.reverse_current_block_enable = prot_ctrl_q[pfrb_pkg::CTL_RCB_EN];
    ctrl.input_overcurrent_enable     =
      prot_ctrl_q[pfrb_pkg::CTL_OCP_EN];
    ctrl.out_overvolt_threshold       = thr_eff;
  end

  // Sense synchronisers; battery present reads 1 from reset
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sense_s1_q <= pfrb_pkg::RST_SENSE;
      sense_s2_q <= pfrb_pkg::RST_SENSE;
    end
    else
    begin
      sense_s1_q <= sense;
      sense_s2_q <= sense_s1_q;
    end
  end

  // Output over-voltage deglitch
  assign dgl_limit = prot_ctrl_q[pfrb_pkg::CTL_DGL_SEL] ?
                     pfrb_pkg::DGL_LONG_CYC :
                     pfrb_pkg::DGL_SHORT_CYC;

  // Trip only after the comparator stays high for the filter time
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      dgl_cnt_q  <= 12'h000;
      ovp_filt_q <= 1'b0;
    end
    else if (!sn.vout_above_thr)
    begin
      dgl_cnt_q  <= 12'h000;
      ovp_filt_q <= 1'b0;
    end
    else if (dgl_cnt_q >= dgl_limit - 12'h001)
    begin
      ovp_filt_q <= 1'b1;
    end
    else
    begin
      dgl_cnt_q <= dgl_cnt_q + 12'h001;
    end
  end

  assign bypass_force_open = ovp_filt_q &&
                             prot_ctrl_q[pfrb_pkg::CTL_OVP_EN];

  // Fault flags
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      usb_prev_q <= 1'b0;
    end
    else
    begin
      usb_prev_q <= sn.usb_above_uvlo;
    end
  end

  always_comb
  begin
    flag_set = 5'h00;
    flag_set[pfrb_pkg::FLG_WDOG]   = wdog_expire;
    flag_set[pfrb_pkg::FLG_OVP]    = ovp_filt_q;
    flag_set[pfrb_pkg::FLG_SWFAIL] = sn.cs_above_fail &&
      !bypass_switch_enable &&
      prot_ctrl_q[pfrb_pkg::CTL_SWF_EN];
    flag_set[pfrb_pkg::FLG_USBOVP] = sn.usb_above_ovp;
    flag_set[pfrb_pkg::FLG_USBINS] =
      sn.usb_above_uvlo != usb_prev_q;
  end

  // Clear exactly what the current read returns
  assign flag_clr = (rd_go && rd_hit && rd_idx == pfrb_pkg::IDX_FLAGS_C) ?
                    flags_q : 5'h00;

  always_comb
  begin
    flags_d = (flags_q & ~flag_clr) | flag_set;
    if (soft_clr)
    begin
      flags_d[3:0] = pfrb_pkg::RST_FLAGS_C[3:0];
    end
    if (reg_rst_q)
    begin
      flags_d[pfrb_pkg::FLG_WDOG] = wdog_expire;
    end
  end

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      flags_q <= pfrb_pkg::RST_FLAGS_C;
    end
    else
    begin
      flags_q <= flags_d;
    end
  end

  // Status
  always_comb
  begin
    status_rd    = 8'h00;
    status_rd[7] = sn.loop_vout;
    status_rd[6] = sn.loop_vbat;
    status_rd[5] = sn.loop_ibat;
    status_rd[4] = sn.loop_ibus;
    status_rd[3] = sn.bus_above_uvlo &&
                   (bypass_switch_enable || adc_enable);
    status_rd[2] = sn.snsp_above_insert;
    status_rd[0] = sn.usb_above_uvlo;
  end

  // Interrupt pin
  // Open drain: drive low only while asserting
  assign int_n_o  = 1'b0;
  assign int_n_oe = |(flags_q[3:0] & ~mask_q) ||
                    flags_q[pfrb_pkg::FLG_WDOG];

endmodule

// ### tb/pfrb_bank_properties.sv
// Port-level checks for the protection register bank.
// Assumes one mclk domain and the active-low asynchronous rst_b.
`timescale 1ns/10ps

module pfrb_bank_properties
(
  input wire logic                          mclk,
  input wire logic                          rst_b,
  input wire logic                          s_axi_awvalid,
  input wire logic                          s_axi_awready,
  input wire logic                          s_axi_wvalid,
  input wire logic                          s_axi_wready,
  input wire logic                          s_axi_bvalid,
  input wire logic [pfrb_pkg::ADDR_W-1:0]   s_axi_araddr,
  input wire logic                          s_axi_arvalid,
  input wire logic                          s_axi_arready,
  input wire logic [31:0]                   s_axi_rdata,
  input wire logic                          s_axi_rvalid,
  input wire logic                          wdog_expire,
  input wire pfrb_pkg::pfrb_ctrl_t          ctrl,
  input wire logic                          bypass_force_open,
  input wire logic                          int_n_o,
  input wire logic                          int_n_oe
);
  logic [7:0] rd_idx_q;
  logic [7:0] rsv_mask;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_b);

  // Remembers which register the pending read returns
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      rd_idx_q <= 8'hff;
    else if (s_axi_arvalid && s_axi_arready)
      rd_idx_q <= s_axi_araddr[9:2];
  end

  always_comb
  begin
    case (rd_idx_q)
      pfrb_pkg::IDX_PROT_CTRL: rsv_mask = 8'h20;
      pfrb_pkg::IDX_OVP_THR:   rsv_mask = 8'h80;
      pfrb_pkg::IDX_MASK_C:    rsv_mask = 8'hf0;
      pfrb_pkg::IDX_FLAGS_C:   rsv_mask = 8'he0;
      pfrb_pkg::IDX_STATUS:    rsv_mask = 8'h02;
      default:                 rsv_mask = 8'hff;
    endcase
  end

  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence

  sequence s_rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence

  a_write_answer: assert property (s_wr_taken |-> ##[1:2] s_axi_bvalid)
    else $error("write response missing");
  a_read_answer: assert property (s_rd_taken |=> s_axi_rvalid)
    else $error("read data missing");
  a_write_refused: assert property
    (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  a_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while data pending");
  a_wdog_defaults: assert property (wdog_expire |=> ctrl == 14'h1194)
    else $error("controls not restored by watchdog");
  a_wdog_irq: assert property (wdog_expire |=> int_n_oe [*3])
    else $error("watchdog flag not driving interrupt");
  a_thr_saturate: assert property
    (ctrl.out_overvolt_threshold <= 7'h50)
    else $error("threshold above saturation code");
  a_force_open_gate: assert property (bypass_force_open |->
    ctrl.out_overvolt_protect_enable)
    else $error("switch forced open while protection off");
  a_reserved_zero: assert property (s_axi_rvalid |->
    s_axi_rdata[31:8] == 24'h0 && (s_axi_rdata[7:0] & rsv_mask) == 8'h00)
    else $error("reserved bit read as one");
  a_pin_drive_low: assert property (int_n_oe |-> int_n_o == 1'h0)
    else $error("interrupt pin driven high");
endmodule

bind pfrb_bank pfrb_bank_properties pfrb_bank_properties_i (.*);

// ### tb/pfrb_host_model.sv
// Host processor model: AXI4-Lite master for the register bank.
// Assumes the slave on the same mclk; bench calls write and read.
`timescale 1ns/10ps

module pfrb_host_model
(
  input  wire logic        mclk,
  output logic [9:0]       s_axi_awaddr,
  output logic             s_axi_awvalid,
  input  wire logic        s_axi_awready,
  output logic [31:0]      s_axi_wdata,
  output logic [3:0]       s_axi_wstrb,
  output logic             s_axi_wvalid,
  input  wire logic        s_axi_wready,
  input  wire logic [1:0]  s_axi_bresp,
  input  wire logic        s_axi_bvalid,
  output logic             s_axi_bready,
  output logic [9:0]       s_axi_araddr,
  output logic             s_axi_arvalid,
  input  wire logic        s_axi_arready,
  input  wire logic [31:0] s_axi_rdata,
  input  wire logic [1:0]  s_axi_rresp,
  input  wire logic        s_axi_rvalid,
  output logic             s_axi_rready
);
  // Response channels always accepted, so no ready toggling
  initial
  begin
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = '0;
    {s_axi_bready, s_axi_rready} = 2'h3;
  end

  task automatic write(input logic [9:0] a, input logic [7:0] d,
                       output logic [1:0] r);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= {24'h000000, d};
    s_axi_wstrb   <= 4'hf;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid  <= 1'h1;
    do
    begin
      @(posedge mclk);
      if (s_axi_awvalid && s_axi_awready)
      begin
        s_axi_awvalid <= 1'h0;
        s_axi_awaddr  <= ~a;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        s_axi_wvalid <= 1'h0;
        s_axi_wdata  <= ~s_axi_wdata;
      end
    end
    while (!s_axi_bvalid);
    r = s_axi_bresp;
  endtask

  task automatic read(input logic [9:0] a, output logic [31:0] d,
                      output logic [1:0] r);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'h1;
    do
    begin
      @(posedge mclk);
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_arvalid <= 1'h0;
        s_axi_araddr  <= ~a;
      end
    end
    while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask
endmodule

// ### tb/pfrb_bank_tb.sv
// Self-checking bench for the protection register bank.
// Assumes the host model as bus master and bench-driven analog levels.
`timescale 1ns/10ps

module pfrb_bank_tb;
  logic                  mclk, rst_b;
  logic [9:0]            s_axi_awaddr, s_axi_araddr;
  logic [31:0]           s_axi_wdata, s_axi_rdata;
  logic [3:0]            s_axi_wstrb;
  logic [1:0]            s_axi_bresp, s_axi_rresp;
  logic                  s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic                  s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic                  s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic                  s_axi_rready, bypass_switch_enable, adc_enable;
  logic                  wdog_expire, bypass_force_open, int_n_o, int_n_oe;
  pfrb_pkg::pfrb_sense_t sense;
  pfrb_pkg::pfrb_ctrl_t  ctrl;
  int                    bad_count, cmp_count;
  logic [7:0]            thr_w [3] = '{8'hff, 8'h50, 8'h4f};
  logic [31:0]           thr_p [3] = '{32'h50, 32'h50, 32'h4f};

  pfrb_bank pfrb_bank_i (.*);
  pfrb_host_model pfrb_host_model_i (.*);

  always #4 mclk = ~mclk;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("MISMATCH t=%0t seen %h want %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [1:0] r;
    pfrb_host_model_i.write({idx, 2'h0}, d, r);
    check({30'h0, r}, {30'h0, pfrb_pkg::RESP_OKAY});
  endtask

  task automatic rd_raw(input logic [9:0] a, input logic [7:0] e,
                        input logic [1:0] er);
    logic [31:0] d;
    logic [1:0]  r;
    pfrb_host_model_i.read(a, d, r);
    check(d, {24'h0, e});
    check({30'h0, r}, {30'h0, er});
  endtask

  task automatic rd(input logic [7:0] idx, input logic [7:0] e);
    rd_raw({idx, 2'h0}, e, pfrb_pkg::RESP_OKAY);
  endtask

  task automatic pulse_wdog();
    wdog_expire <= 1'h1;
    @(posedge mclk);
    wdog_expire <= 1'h0;
    repeat (5) @(posedge mclk);
  endtask

  task automatic results();
    $display("Compared %0d, mismatched %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge mclk);
    bad_count++;
    results();
  end

  initial
  begin
    mclk = 1'h0;
    rst_b = 1'h0;
    sense = 10'h010;
    {bypass_switch_enable, adc_enable, wdog_expire} = 3'h0;
    repeat (6) @(posedge mclk);
    rst_b <= 1'h1;
    repeat (4) @(posedge mclk);
    rd(pfrb_pkg::IDX_PROT_CTRL, 8'h43);
    rd(pfrb_pkg::IDX_OVP_THR, 8'h14);
    rd(pfrb_pkg::IDX_MASK_C, 8'h01);
    rd(pfrb_pkg::IDX_FLAGS_C, 8'h00);
    rd(pfrb_pkg::IDX_STATUS, 8'h04);
    rd_raw(10'h3fc, 8'h00, pfrb_pkg::RESP_SLVERR);
    $display("Test defaults done");
    wr(pfrb_pkg::IDX_PROT_CTRL, 8'hff);
    rd(pfrb_pkg::IDX_PROT_CTRL, 8'hdf);
    check({18'h0, ctrl}, 32'h3f94);
    foreach (thr_w[i])
    begin
      wr(pfrb_pkg::IDX_OVP_THR, thr_w[i]);
      rd(pfrb_pkg::IDX_OVP_THR, thr_w[i] & 8'h7f);
      check({25'h0, ctrl.out_overvolt_threshold}, thr_p[i]);
    end
    wr(pfrb_pkg::IDX_MASK_C, 8'hff);
    rd(pfrb_pkg::IDX_MASK_C, 8'h0f);
    wr(pfrb_pkg::IDX_FLAGS_C, 8'hff);
    rd(pfrb_pkg::IDX_FLAGS_C, 8'h00);
    $display("Test access done");
    wr(pfrb_pkg::IDX_PROT_CTRL, 8'h06);
    sense <= 10'h017;
    repeat (6) @(posedge mclk);
    sense <= 10'h011;
    repeat (6) @(posedge mclk);
    check({31'h0, int_n_oe}, 32'h0);
    rd(pfrb_pkg::IDX_FLAGS_C, 8'h07);
    rd(pfrb_pkg::IDX_FLAGS_C, 8'h00);
    wr(pfrb_pkg::IDX_MASK_C, 8'h00);
    sense <= 10'h010;
    repeat (6) @(posedge mclk);
    check({31'h0, int_n_oe}, 32'h1);
    rd(pfrb_pkg::IDX_FLAGS_C, 8'h01);
    check({31'h0, int_n_oe}, 32'h0);
    bypass_switch_enable <= 1'h1;
    sense <= 10'h014;
    repeat (6) @(posedge mclk);
    rd(pfrb_pkg::IDX_FLAGS_C, 8'h00);
    // Host masks insertion events, no external blocking switch fitted
    wr(pfrb_pkg::IDX_MASK_C, 8'h01);
    $display("Test flags done");
    // Open the switch only once the failure level has left the syncs
    sense <= 10'h3f1;
    repeat (3) @(posedge mclk);
    bypass_switch_enable <= 1'h0;
    repeat (2) @(posedge mclk);
    rd(pfrb_pkg::IDX_STATUS, 8'hf5);
    adc_enable <= 1'h1;
    repeat (3) @(posedge mclk);
    rd(pfrb_pkg::IDX_STATUS, 8'hfd);
    adc_enable <= 1'h0;
    sense <= 10'h010;
    repeat (4) @(posedge mclk);
    rd(pfrb_pkg::IDX_FLAGS_C, 8'h01);
    $display("Test status done");
    wr(pfrb_pkg::IDX_PROT_CTRL, 8'h0a);
    sense <= 10'h01c;
    repeat (480) @(posedge mclk);
    check({31'h0, bypass_force_open}, 32'h0);
    repeat (50) @(posedge mclk);
    check({31'h0, bypass_force_open}, 32'h1);
    sense <= 10'h010;
    repeat (5) @(posedge mclk);
    check({31'h0, bypass_force_open}, 32'h0);
    rd(pfrb_pkg::IDX_FLAGS_C, 8'h08);
    rd(pfrb_pkg::IDX_FLAGS_C, 8'h00);
    wr(pfrb_pkg::IDX_PROT_CTRL, 8'h1a);
    sense <= 10'h018;
    repeat (2480) @(posedge mclk);
    check({31'h0, bypass_force_open}, 32'h0);
    repeat (50) @(posedge mclk);
    check({31'h0, bypass_force_open}, 32'h1);
    sense <= 10'h010;
    repeat (5) @(posedge mclk);
    rd(pfrb_pkg::IDX_FLAGS_C, 8'h08);
    $display("Test deglitch done");
    wr(pfrb_pkg::IDX_PROT_CTRL, 8'h1f);
    wr(pfrb_pkg::IDX_MASK_C, 8'h0f);
    pulse_wdog();
    check({31'h0, int_n_oe}, 32'h1);
    rd(pfrb_pkg::IDX_PROT_CTRL, 8'h43);
    rd(pfrb_pkg::IDX_MASK_C, 8'h01);
    rd(pfrb_pkg::IDX_FLAGS_C, 8'h10);
    check({31'h0, int_n_oe}, 32'h0);
    pulse_wdog();
    wr(pfrb_pkg::IDX_SOFT_CTRL, 8'h01);
    repeat (2) @(posedge mclk);
    rd(pfrb_pkg::IDX_FLAGS_C, 8'h00);
    check({31'h0, int_n_oe}, 32'h0);
    $display("Test resets done");
    results();
  end
endmodule
